//--- hdl/flyback_defines.svh
// timing constants and counts for the flyback gate and protection controller
// assumes a 10 MHz clock; included by bare name
`ifndef FLYBACK_DEFINES_SVH
`define FLYBACK_DEFINES_SVH

`define CLK_PERIOD_NS        100
`define LEB_TIME_NS          150
`define LEB_CYCLES           ((`LEB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BROWNOUT_TIME_MS     30
`define BROWNOUT_CYCLES      (`BROWNOUT_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define UV_BLANK_TIME_MS     45
`define UV_BLANK_CYCLES      (`UV_BLANK_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define UV_DEBOUNCE_DEFAULT  4
`define OV_DEBOUNCE_DEFAULT  4
`define PERIOD_CYCLES_DEF    100
`define MAX_ON_CYCLES_DEF    70
`define SAMPLE_DELAY_DEF     20

`endif

//--- hdl/flyback_pkg.sv
// types shared by the flyback gate and protection controller
// assumes nothing beyond a single clock domain
package flyback_pkg;
  // comparator flags from the analog front end
  typedef struct packed {
    logic cur_limit;     // sense reached current_limit_threshold
    logic burst_low;     // feedback below burst_stop_threshold
    logic burst_high;    // feedback above burst_resume_threshold
    logic supply_on;     // supply at supply_turn_on_level
    logic supply_off;    // supply at supply_turn_off_level
    logic supply_reset;  // supply at the 2.5 V reset level
    logic supply_ov;     // supply above 28 V
    logic line_low;      // on-time line current below 160 uA
    logic over_temp;     // junction over temperature
    logic shutdown_low;  // external_shutdown_pin below shutdown_threshold
    logic sense_uv;      // aux_sense_pin sample below sense_undervolt_level
    logic sense_ov;      // aux_sense_pin sample above sense_overvolt_level
  } comp_flags_t;

  // fault status
  typedef struct packed {
    logic supply_ov;
    logic brownout;
    logic sense_uv;
    logic sense_ov;
    logic over_temp;
    logic shutdown;
  } fault_flags_t;

  // supervisor states
  typedef enum logic [1:0] {
    ST_STARTUP,   // high-voltage source charging the supply
    ST_RUN,       // switching allowed
    ST_FAULT_AR,  // auto-restart fault, waiting for turn-off level
    ST_LATCHED    // latched fault, cycling the supply
  } sup_state_t;
endpackage

//--- hdl/sense_debounce.sv
// counts consecutive switching-cycle samples of a sense flag
// assumes sample_stb pulses once per cycle
`timescale 1ns/1ps
module sense_debounce #(
  parameter int COUNT = 4  // samples that must be exceeded
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // sample input
  input  wire logic sample_stb,  // one pulse per switching cycle
  input  wire logic flag,        // condition at the sample
  input  wire logic enable,      // detection allowed
  // result
  output logic      trip         // one-cycle pulse when count exceeded
);
  localparam int W = $clog2(COUNT + 2);

  logic [W-1:0] cnt_r;   // consecutive samples seen
  logic [W-1:0] cnt_nxt;
  logic         trip_r;
  logic         trip_nxt;

  // --------------------------------------------------------
  // next count
  // --------------------------------------------------------
  always_comb begin
    cnt_nxt  = cnt_r;
    trip_nxt = 1'b0;
    if (!enable) begin
      cnt_nxt = '0;  // blanked: forget history
    end else if (sample_stb) begin
      if (!flag) begin
        cnt_nxt = '0;
      end else if (cnt_r == W'(COUNT)) begin
        trip_nxt = 1'b1;  // more than COUNT cycles in a row
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  // register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r  <= '0;
      trip_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      trip_r <= trip_nxt;
    end
  end

  assign trip = trip_r;
endmodule

//--- hdl/flyback_gate_protection_ctrl.sv
// gating and fault sequencing for an offline flyback pwm controller
// assumes comparator flags synchronous to clk; drives the gate driver input
//
// Contract
// - current limit ends gate pulse at once
// - burst low flag stops gate pulses
// - burst high flag resumes pulses, hysteretic
// - ignore current limit 150 ns after turn-on
// - blanking prevents current limit terminating pulse
// - ramp restarts aligned with each turn-on
// - turn-on level disables startup, starts switching
// - supply overvolt and brownout auto-restart
// - sense overvolt, temperature, shutdown latch
// - auto-restart clears at turn-off, startup on
// - after clear, switch again at turn-on
// - latched: startup on at turn-off, fault kept
// - latched: turn-on only disables startup source
// - latched fault clears only at 2.5 V
// - supply over 28 V raises fault
// - line current low over 30 ms: brownout
// - over temperature stops gate, latches
// - sample sense pin near diode conduction end
// - sense undervolt debounced raises auto-restart
// - undervolt detection blanked 45 ms after power-on
// - sense overvolt debounced disables gate, latches
// - shutdown pin low enters latched fault
`timescale 1ns/1ps
`include "flyback_defines.svh"
module flyback_gate_protection_ctrl #(
  parameter int PERIOD_CYCLES   = `PERIOD_CYCLES_DEF,  // switching period
  parameter int MAX_ON_CYCLES   = `MAX_ON_CYCLES_DEF,  // maximum on-time
  parameter int SAMPLE_DELAY    = `SAMPLE_DELAY_DEF,   // off-time to sense sample
  parameter int UV_DEBOUNCE     = `UV_DEBOUNCE_DEFAULT,
  parameter int OV_DEBOUNCE     = `OV_DEBOUNCE_DEFAULT,
  parameter int BROWNOUT_CYCLES = `BROWNOUT_CYCLES,
  parameter int UV_BLANK_CYCLES = `UV_BLANK_CYCLES
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // analog comparator flags
  input  wire flyback_pkg::comp_flags_t  comp,
  input  wire logic                      pwm_compare,  // loop comparator ends pulse
  // power stage
  output logic                           gate,          // mosfet gate drive
  output logic                           ramp_reset,    // restarts compensation ramp
  output logic                           startup_en,    // high_voltage_startup_pin source
  output logic                           sense_sample,  // sample aux_sense_pin now
  // status
  output flyback_pkg::fault_flags_t      faults,
  output flyback_pkg::sup_state_t        state,
  output logic                           burst_off      // burst hold-off active
);
  // counter widths follow the parameters, so a longer period or interval
  // only needs a new parameter value, never a hand-edited width
  localparam int PW = $clog2(PERIOD_CYCLES + 1);
  localparam int LW = $clog2(`LEB_CYCLES + 1);
  localparam int BW = $clog2(BROWNOUT_CYCLES + 1);
  localparam int UW = $clog2(UV_BLANK_CYCLES + 1);

  // --------------------------------------------------------
  // supervisor and fault state
  // --------------------------------------------------------
  flyback_pkg::sup_state_t   st_r, st_nxt;        // supervisor state
  flyback_pkg::fault_flags_t flt_r, flt_nxt;      // sticky fault flags
  logic [BW-1:0]             bo_cnt_r, bo_cnt_nxt;  // brownout duration
  logic                      lo_r, lo_nxt;         // line-low reading held from on-time
  logic [UW-1:0]             uvb_cnt_r, uvb_cnt_nxt;  // startup blank
  logic                      uv_trip;
  logic                      ov_trip;
  logic                      ar_evt;               // any auto-restart cause
  logic                      latch_evt;            // any latch cause
  flyback_pkg::fault_flags_t new_flt;

  // --------------------------------------------------------
  // switching cycle state
  // --------------------------------------------------------
  logic [PW-1:0] ph_r, ph_nxt;        // position in period
  logic          gate_r, gate_nxt;
  logic [LW-1:0] leb_r, leb_nxt;      // blanking cycles left
  logic          burst_r, burst_nxt;
  logic          ramp_r, ramp_nxt;
  logic          samp_r, samp_nxt;
  logic [PW-1:0] off_r, off_nxt;      // cycles since turn-off
  logic          run_ok;

  assign run_ok = (st_r == flyback_pkg::ST_RUN);

  // the line current is only meaningful while the switch conducts, so its
  // comparator is read during on-time and the result held through off-time;
  // the brownout timer then counts wall-clock cycles, not on-time cycles,
  // so a low line trips after the full interval whatever the duty cycle
  always_comb begin
    bo_cnt_nxt  = bo_cnt_r;
    uvb_cnt_nxt = uvb_cnt_r;
    lo_nxt      = lo_r;
    if (!run_ok) begin
      lo_nxt = 1'b0;  // stale outside switching: measure again on resume
    end else if (gate_r) begin
      lo_nxt = comp.line_low;  // fresh reading each on-time
    end
    if (!lo_r) begin
      bo_cnt_nxt = '0;  // condition cleared, start over
    end else if (bo_cnt_r != BW'(BROWNOUT_CYCLES)) begin
      bo_cnt_nxt = bo_cnt_r + BW'(1);
    end
    if (uvb_cnt_r != UW'(UV_BLANK_CYCLES)) begin
      uvb_cnt_nxt = uvb_cnt_r + UW'(1);
    end
  end

  // debouncers for the sense pin sample
  // both are held off outside run, so a stale count cannot trip a fault
  // the moment switching resumes
  sense_debounce #(.COUNT(UV_DEBOUNCE)) u_uv (
    .clk        (clk),
    .rst        (rst),
    .sample_stb (samp_r),
    .flag       (comp.sense_uv),
    .enable     (uvb_cnt_r == UW'(UV_BLANK_CYCLES) && run_ok),
    .trip       (uv_trip)
  );
  sense_debounce #(.COUNT(OV_DEBOUNCE)) u_ov (
    .clk        (clk),
    .rst        (rst),
    .sample_stb (samp_r),
    .flag       (comp.sense_ov),
    .enable     (run_ok),
    .trip       (ov_trip)
  );

  // --------------------------------------------------------
  // fault detection and supervisor
  // --------------------------------------------------------
  always_comb begin
    new_flt.supply_ov = comp.supply_ov;
    new_flt.brownout  = (bo_cnt_r == BW'(BROWNOUT_CYCLES));
    new_flt.sense_uv  = uv_trip;
    new_flt.sense_ov  = ov_trip;
    new_flt.over_temp = comp.over_temp;
    new_flt.shutdown  = comp.shutdown_low;
    ar_evt    = new_flt.supply_ov | new_flt.brownout | new_flt.sense_uv;
    latch_evt = new_flt.sense_ov | new_flt.over_temp | new_flt.shutdown;
    st_nxt  = st_r;
    flt_nxt = flt_r;
    case (st_r)
      flyback_pkg::ST_STARTUP: begin
        if (comp.supply_on) begin
          st_nxt = flyback_pkg::ST_RUN;
        end
      end
      flyback_pkg::ST_RUN: begin
        // latch class takes priority when both happen together
        if (latch_evt) begin
          st_nxt  = flyback_pkg::ST_LATCHED;
          flt_nxt = flt_r | new_flt;
        end else if (ar_evt) begin
          st_nxt  = flyback_pkg::ST_FAULT_AR;
          flt_nxt = flt_r | new_flt;
        end else if (comp.supply_off) begin
          st_nxt = flyback_pkg::ST_STARTUP;  // plain undervoltage lockout
        end
      end
      flyback_pkg::ST_FAULT_AR: begin
        flt_nxt = flt_r | new_flt;
        if (latch_evt) begin
          st_nxt = flyback_pkg::ST_LATCHED;
        end else if (comp.supply_off) begin
          // a cause that still stands is caught again once switching resumes
          st_nxt  = flyback_pkg::ST_STARTUP;
          flt_nxt = '0;
        end
      end
      flyback_pkg::ST_LATCHED: begin
        flt_nxt = flt_r | new_flt;  // fault stays set
        // only the deep reset level clears; the turn-off level merely recharges
        if (comp.supply_reset) begin
          st_nxt  = flyback_pkg::ST_STARTUP;
          flt_nxt = '0;
        end
      end
      default: begin
        st_nxt = flyback_pkg::ST_STARTUP;
      end
    endcase
  end

  // supervisor registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r      <= flyback_pkg::ST_STARTUP;
      flt_r     <= '0;
      bo_cnt_r  <= '0;
      lo_r      <= 1'b0;
      uvb_cnt_r <= '0;
    end else begin
      st_r      <= st_nxt;
      flt_r     <= flt_nxt;
      bo_cnt_r  <= bo_cnt_nxt;
      lo_r      <= lo_nxt;
      uvb_cnt_r <= uvb_cnt_nxt;
    end
  end

  // --------------------------------------------------------
  // startup source control
  // --------------------------------------------------------
  // the source toggles with supply levels in every state; in the latched
  // state this makes the supply cycle until the line energy is gone
  logic su_r, su_nxt;
  always_comb begin
    su_nxt = su_r;
    if (comp.supply_off) begin
      su_nxt = 1'b1;
    end else if (comp.supply_on) begin
      su_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      su_r <= 1'b1;
    end else begin
      su_r <= su_nxt;
    end
  end

  // --------------------------------------------------------
  // switching cycle: gate, blanking, burst, ramp, sample
  // --------------------------------------------------------
  always_comb begin
    ph_nxt    = (ph_r == PW'(PERIOD_CYCLES - 1)) ? '0 : ph_r + PW'(1);
    gate_nxt  = gate_r;
    leb_nxt   = (leb_r != '0) ? leb_r - LW'(1) : leb_r;
    burst_nxt = burst_r;
    ramp_nxt  = 1'b0;
    samp_nxt  = 1'b0;
    off_nxt   = (off_r != '1) ? off_r + PW'(1) : off_r;
    // burst hysteresis
    if (comp.burst_low) begin
      burst_nxt = 1'b1;
    end else if (comp.burst_high) begin
      burst_nxt = 1'b0;
    end
    if (!run_ok || latch_evt || ar_evt) begin
      gate_nxt = 1'b0;  // faults stop the gate at once
    end else if (ph_r == PW'(PERIOD_CYCLES - 1)) begin
      if (!burst_nxt) begin
        // blanking loads on the same edge the gate rises, so the turn-on
        // spike can never end the pulse
        gate_nxt = 1'b1;        // turn on at period start
        leb_nxt  = LW'(`LEB_CYCLES);
        ramp_nxt = 1'b1;
      end
    end else if (gate_r) begin
      if (comp.cur_limit && leb_r == '0) begin
        gate_nxt = 1'b0;
      end else if (pwm_compare && leb_r == '0) begin
        gate_nxt = 1'b0;  // normal loop termination, also blanked
      end else if (ph_r >= PW'(MAX_ON_CYCLES - 1)) begin
        gate_nxt = 1'b0;  // maximum duty guard
      end
    end
    if (gate_r && !gate_nxt) begin
      off_nxt = '0;
    end
    // sample near the end of diode conduction, once per cycle
    // limitation: the point is a fixed delay after turn-off, not a measured
    // fraction of the conduction time, so it suits one load range best
    if (!gate_r && off_r == PW'(SAMPLE_DELAY)) begin
      samp_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ph_r    <= '0;
      gate_r  <= 1'b0;
      leb_r   <= '0;
      burst_r <= 1'b0;
      ramp_r  <= 1'b0;
      samp_r  <= 1'b0;
      off_r   <= '1;
    end else begin
      ph_r    <= ph_nxt;
      gate_r  <= gate_nxt;
      leb_r   <= leb_nxt;
      burst_r <= burst_nxt;
      ramp_r  <= ramp_nxt;
      samp_r  <= samp_nxt;
      off_r   <= off_nxt;
    end
  end

  // --------------------------------------------------------
  // outputs
  // --------------------------------------------------------
  // every output comes straight from a flip-flop, so none can glitch
  assign gate         = gate_r;
  assign ramp_reset   = ramp_r;
  assign startup_en   = su_r;
  assign sense_sample = samp_r;
  assign faults       = flt_r;
  assign state        = st_r;
  assign burst_off    = burst_r;
endmodule

//--- dv/flyback_ctrl_asserts.sv
// assertions for the flyback gate and protection controller
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module flyback_ctrl_asserts (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      rst,
  // watched ports
  input wire flyback_pkg::comp_flags_t  comp,
  input wire logic                      gate,
  input wire logic                      ramp_reset,
  input wire logic                      startup_en,
  input wire flyback_pkg::fault_flags_t faults,
  input wire flyback_pkg::sup_state_t   state,
  input wire logic                      burst_off
);
  // ------------------------------------
  // one clock domain, reset disables all
  // ------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ramp_align_a: assert property ($rose(gate) == ramp_reset)
    else $error("ramp restart not on gate turn-on");
  // a fault may drop the gate inside blanking, nothing else may
  blank_hold_a: assert property ($rose(gate) |=> (gate || faults != '0))
    else $error("pulse ended inside blanking");
  limit_end_a: assert property (gate && comp.cur_limit |-> ##[1:4] !gate)
    else $error("current limit did not end pulse");
  burst_stop_a: assert property (
    state == flyback_pkg::ST_RUN && comp.burst_low && !comp.burst_high |-> ##[1:2] burst_off)
    else $error("burst hold-off not entered");
  burst_go_a: assert property (
    burst_off && comp.burst_high && !comp.burst_low |-> ##[1:2] !burst_off)
    else $error("burst hold-off not left");
  // a resume level seen this cycle may start a pulse at the next period start
  burst_hold_a: assert property (burst_off && !gate && (!comp.burst_high || comp.burst_low) |=> !gate)
    else $error("pulse during burst hold-off");
  start_run_a: assert property (
    state == flyback_pkg::ST_STARTUP && comp.supply_on && !comp.supply_off
    |=> state == flyback_pkg::ST_RUN && !startup_en)
    else $error("no start at turn-on");
  latch_enter_a: assert property (
    state == flyback_pkg::ST_RUN && (comp.over_temp || comp.shutdown_low)
    |=> state == flyback_pkg::ST_LATCHED && !gate)
    else $error("latch fault missed");
  ar_enter_a: assert property (
    state == flyback_pkg::ST_RUN && comp.supply_ov && !comp.over_temp && !comp.shutdown_low
    |=> state == flyback_pkg::ST_FAULT_AR && !gate)
    else $error("supply overvolt missed");
  ar_clear_a: assert property (
    state == flyback_pkg::ST_FAULT_AR && comp.supply_off
    |=> state == flyback_pkg::ST_STARTUP && faults == '0 && startup_en)
    else $error("auto-restart not cleared");
  latch_keep_a: assert property (
    state == flyback_pkg::ST_LATCHED && !comp.supply_reset
    |=> state == flyback_pkg::ST_LATCHED && !gate && faults != '0)
    else $error("latched fault left early");
endmodule

bind flyback_gate_protection_ctrl flyback_ctrl_asserts chk_u (
  .clk(clk), .rst(rst), .comp(comp), .gate(gate), .ramp_reset(ramp_reset),
  .startup_en(startup_en), .faults(faults), .state(state), .burst_off(burst_off)
);

//--- dv/flyback_frontend_model.sv
// front-end model: supply and current-sense comparators
// assumes the bench sets supply in millivolts and ramp length in cycles
`timescale 1ns/1ps
module flyback_frontend_model (
  // clock and gate drive
  input  wire logic                     clk,
  input  wire logic                     gate,
  // analog conditions from the bench
  input  int                            supply_mv,
  input  int                            lim_delay,
  input  wire flyback_pkg::comp_flags_t ext,
  // comparator levels
  output flyback_pkg::comp_flags_t      comp
);
  int on_cnt;  // cycles of conduction, stands for the current ramp
  // current only builds while the switch conducts
  always_ff @(posedge clk) begin
    on_cnt <= gate ? on_cnt + 1 : 0;
  end
  // comparator thresholds; flags not modelled pass from the bench
  always_comb begin
    comp              = ext;
    comp.cur_limit    = gate && (on_cnt >= lim_delay);
    comp.supply_on    = supply_mv >= 17500;
    comp.supply_off   = supply_mv <= 5800;
    comp.supply_reset = supply_mv <= 2500;
    comp.supply_ov    = supply_mv > 28000;
  end
endmodule

//--- dv/test_flyback_gate_protection_ctrl.sv
// self-checking bench for the flyback gate and protection controller
// assumes the front-end model supplies all comparator levels
`timescale 1ns/1ps
module test_flyback_gate_protection_ctrl;
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      pwm_compare = 1'b0;  // loop idle: limit ends pulses
  int                        supply_mv = 0;
  int                        lim_delay = 8;
  flyback_pkg::comp_flags_t  ext = '0;
  flyback_pkg::comp_flags_t  comp;
  logic                      gate, ramp_reset, startup_en, sense_sample, burst_off;
  flyback_pkg::fault_flags_t faults;
  flyback_pkg::sup_state_t   state;
  int                        bad_count = 0;
  int                        check_count = 0;
  int                        w;
  int                        sdl;  // cycles from turn-off to the sense sample
  flyback_pkg::fault_flags_t fx;

  always #50 clk = ~clk;

  // short counts keep the run brief
  flyback_gate_protection_ctrl #(.BROWNOUT_CYCLES(50), .UV_BLANK_CYCLES(50)) dut_u (
    .clk(clk), .rst(rst), .comp(comp), .pwm_compare(pwm_compare), .gate(gate),
    .ramp_reset(ramp_reset), .startup_en(startup_en), .sense_sample(sense_sample),
    .faults(faults), .state(state), .burst_off(burst_off));
  flyback_frontend_model fe_u (
    .clk(clk), .gate(gate), .supply_mv(supply_mv), .lim_delay(lim_delay), .ext(ext), .comp(comp));

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic miss(string msg);
    bad_count++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask
  task automatic check_bit(logic got, logic exp, string msg);
    check_count++;
    if (got !== exp) miss(msg);
  endtask
  task automatic check_state(flyback_pkg::sup_state_t exp, string msg);
    check_count++;
    if (state !== exp) miss(msg);
  endtask
  task automatic check_faults(flyback_pkg::fault_flags_t exp, string msg);
    check_count++;
    if (faults !== exp) miss(msg);
  endtask
  task automatic check_range(int got, int lo, int hi, string msg);
    check_count++;
    if (got < lo || got > hi) miss(msg);
  endtask
  // bounded wait for a supervisor state
  task automatic wait_state(flyback_pkg::sup_state_t exp, int n);
    for (int i = 0; i < n && state !== exp; i++) @(negedge clk);
    check_state(exp, "state not reached");
    if (state !== exp) test_done();
  endtask
  // width of the next pulse in cycles, then delay to the sense sample
  task automatic pulse_width(output int n, output int s);
    n = 0;
    s = 0;
    for (int i = 0; i < 300 && gate !== 1'b1; i++) @(negedge clk);
    check_bit(ramp_reset, 1'b1, "ramp restart missing");
    while (gate === 1'b1 && n < 100) begin
      n++;
      @(negedge clk);
    end
    while (sense_sample !== 1'b1 && s < 100) begin
      s++;
      @(negedge clk);
    end
  endtask
  task automatic set_mv(int mv);
    @(posedge clk);
    supply_mv <= mv;
  endtask
  // raise or drop one fault condition: 0..2 auto-restart, 3..5 latch
  task automatic set_fault(int k, logic on);
    @(posedge clk);
    case (k)
      0: supply_mv <= on ? 29000 : 12000;
      1: ext.line_low <= on;
      2: ext.sense_uv <= on;
      3: ext.sense_ov <= on;
      4: ext.over_temp <= on;
      default: ext.shutdown_low <= on;
    endcase
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check_bit(startup_en, 1'b1, "startup source off after reset");
    set_mv(18000);
    wait_state(flyback_pkg::ST_RUN, 20);
    @(negedge clk);
    check_bit(startup_en, 1'b0, "startup source still on");
    set_mv(12000);
    // limit past blanking, then limit already high at turn-on
    pulse_width(w, sdl);
    pulse_width(w, sdl);
    check_range(w, 9, 11, "limit did not end pulse");
    check_range(sdl, 19, 22, "sense sample not near conduction end");
    @(posedge clk);
    lim_delay <= 0;
    pulse_width(w, sdl);
    pulse_width(w, sdl);
    check_range(w, 3, 4, "pulse cut inside blanking");
    // the loop comparator also ends pulses, but only after blanking
    @(posedge clk);
    lim_delay   <= 200;
    pwm_compare <= 1'b1;
    pulse_width(w, sdl);
    check_range(w, 3, 3, "loop end not held off by blanking");
    // with no limit and no loop end the on-time guard ends the pulse
    @(posedge clk);
    pwm_compare <= 1'b0;
    pulse_width(w, sdl);
    check_range(w, 70, 70, "pulse not ended at maximum on-time");
    @(posedge clk);
    lim_delay <= 8;
    // burst hold-off and resume
    @(posedge clk);
    ext.burst_low <= 1'b1;
    repeat (120) @(negedge clk);
    check_bit(burst_off, 1'b1, "burst hold-off not set");
    w = 0;
    repeat (200) begin
      @(negedge clk);
      if (gate === 1'b1) w++;
    end
    check_range(w, 0, 0, "pulses during burst");
    @(posedge clk);
    ext.burst_low <= 1'b0;
    ext.burst_high <= 1'b1;
    pulse_width(w, sdl);
    check_range(w, 9, 11, "no resume above burst level");
    @(posedge clk);
    ext.burst_high <= 1'b0;
    // each fault kind, its class and its recovery
    for (int k = 0; k < 6; k++) begin
      fx = flyback_pkg::fault_flags_t'(6'h20 >> k);
      set_fault(k, 1'b1);
      wait_state(k < 3 ? flyback_pkg::ST_FAULT_AR : flyback_pkg::ST_LATCHED, 1500);
      check_faults(fx, "fault flag");
      check_bit(gate, 1'b0, "gate on under fault");
      set_fault(k, 1'b0);
      set_mv(5000);
      repeat (3) @(negedge clk);
      check_bit(startup_en, 1'b1, "startup source off at turn-off");
      if (k < 3) begin
        check_state(flyback_pkg::ST_STARTUP, "auto-restart not cleared");
        check_faults('0, "auto-restart flags kept");
      end else begin
        check_faults(fx, "latched flag lost at turn-off");
        set_mv(18000);
        repeat (3) @(negedge clk);
        check_bit(startup_en, 1'b0, "startup source on at turn-on");
        check_state(flyback_pkg::ST_LATCHED, "latched fault restarted");
        set_mv(2000);
        wait_state(flyback_pkg::ST_STARTUP, 5);
        check_faults('0, "latched flag not cleared");
      end
      set_mv(18000);
      wait_state(flyback_pkg::ST_RUN, 5);
      set_mv(12000);
    end
    test_done();
  end
endmodule
